// ---- sim/pfp_pg_mon.sv ----
// Purpose: System-side watcher of the power-good pin of the fault block
// Assumes: Pin is sampled on the core clock, same domain as the block
// Notes:   Counts edges only; the bench judges whether the counts are right
`timescale 1ns/1ps
module pfp_pg_mon (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Watched pin and edge counts
  input  wire logic pg,
  output int        rise_cnt,
  output int        fall_cnt
);
  logic pg_q;

  ////////////////////////////////////////////////////////////////////////
  // Edge counting; reset clears history so reset-time levels do not count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_q     <= 1'b0;
      rise_cnt <= 0;
      fall_cnt <= 0;
    end else begin
      pg_q <= pg;
      if (pg && !pg_q) rise_cnt <= rise_cnt + 1;
      if (!pg && pg_q) fall_cnt <= fall_cnt + 1;
    end
  end
endmodule

// ---- sim/test_pol_fault_protection.sv ----
// Purpose: Self-checking bench for the regulator fault-protection block
// Assumes: Retry period shortened to 400 cycles, still above the 150-cycle
//          qualifier so a restart never sees a stale flag; delays in a window
// Notes:   Outputs are read just after an edge, so they lag by one cycle
`timescale 1ns/1ps
module test_pol_fault_protection;
  import pfp_pkg::*;
  localparam int RCYC = 400;
  logic        core_clk, resetn, hsel, hwrite, enable, ramping;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, turn_off, pg, ot_warn, irq;
  logic [15:0] vout_mv, vset_mv, vtrack_mv, iout_ma, irated_ma;
  logic [7:0]  temp_c;
  int          failures, total_checks, rise_cnt, fall_cnt;
  wire  [3:0]  outs = {irq, pg, ot_warn, turn_off};
  // Fault table: ctrl, setpoint, vout, iout, ramping, expected cause
  int tbl [20][6] = '{'{'h2A, 2500, 3250, 0, 0, 0}, '{'h2A, 2500, 3260, 0, 0, 2}, '{'h0A, 2500, 2760, 0, 0, 2},
    '{'h2A, 700, 950, 0, 0, 0}, '{'h2A, 700, 1010, 0, 0, 2}, '{'h2A, 2500, 1870, 0, 0, 4},
    '{'h2A, 2500, 1880, 0, 0, 0}, '{'hAA, 2500, 2100, 0, 0, 4}, '{'h2A, 2500, 1500, 0, 1, 0},
    '{'h2A, 2500, 2500, 1510, 0, 1}, '{'h2A, 2500, 2500, 1490, 0, 0}, '{'h20, 2500, 2500, 610, 0, 1},
    '{'h2A, 2500, 2500, -2000, 0, 0}, '{'h402A, 2500, 2740, 0, 1, 0}, '{'h402A, 2500, 2240, 0, 1, 16},
    '{'h402A, 2500, 2760, 0, 1, 16}, '{'h2A, 2500, 2800, 0, 1, 0}, '{'h1A, 2500, 3010, 0, 0, 2},
    '{'h6A, 2500, 1990, 0, 0, 4}, '{'h2F, 2500, 2500, 1510, 0, 1}};
  // Window table: vout, high lower bound, expected power good
  int pgt [6][3] = '{'{2240, 0, 0}, '{2300, 0, 1}, '{2300, 1, 0}, '{2750, 1, 1}, '{2760, 1, 0}, '{2500, 0, 1}};

  ////////////////////////////////////////////////////////////////////////
  // Device and system-side watcher
  pfp_fault_prot #(.RETRY_CYC(RCYC)) i_dut (.CORE_CLK(core_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .ENABLE(enable), .RAMPING(ramping), .VOUT_MV(vout_mv),
    .VSET_MV(vset_mv), .VTRACK_MV(vtrack_mv), .IOUT_MA(iout_ma), .IRATED_MA(irated_ma), .TEMP_C(temp_c),
    .TURN_OFF(turn_off), .POWER_GOOD_OUTPUT(pg), .OT_WARN(ot_warn), .IRQ(irq));
  pfp_pg_mon i_mon (.clk(core_clk), .rst_n(resetn), .pg(pg), .rise_cnt(rise_cnt), .fall_cnt(fall_cnt));

  ////////////////////////////////////////////////////////////////////////
  // Report and comparison
  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master; every wait is bounded so a stuck slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("BAD %0t bus stalled", $time);
      test_done();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string msg);
    bus(1'b0, a, 32'h00000000);
    check(rd & m, e, msg);
  endtask

  // Waits up to hi edges for output s to reach v; hit says whether it must, no sooner than lo
  task automatic watch(input int s, input logic v, input int lo, input int hi, input logic hit);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (outs[s] !== v && n < hi);
    check({31'h0, outs[s] === v && n >= lo}, {31'h0, hit}, $sformatf("output %0d after %0d", s, n));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {failures, total_checks} = '0;
    {resetn, hsel, hwrite, enable, ramping, htrans, haddr, hwdata} = '0;
    {vout_mv, vset_mv, vtrack_mv, iout_ma, irated_ma, temp_c} =
      {16'h09C4, 16'h09C4, 16'h09C4, 16'h0000, 16'h03E8, 8'h19};
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    watch(2, 1'b1, 145, 165, 1'b1);
    rdc(OFF_CTRL, 32'hFFFFFFFF, 32'h0000002A, "control defaults");
    check({31'h0, hresp}, 32'h00000000, "bus response");
    rdc(OFF_IRQE, 32'hFFFFFFFF, 32'h00000000, "enable default");
    rdc(8'h40, 32'hFFFFFFFF, 32'h00000000, "unmapped read");
    // Window bounds, both lower choices and the fixed upper edge
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL, pgt[i][1] != 0 ? 32'h0000012A : 32'h0000002A);
      vout_mv <= 16'(pgt[i][0]);
      repeat (200) @(posedge core_clk);
      check({31'h0, pg}, 32'(pgt[i][2]), "power good level");
    end
    check(32'(rise_cnt), 32'h00000004, "power good rises");
    check(32'(fall_cnt), 32'h00000003, "power good falls");
    // Trip levels, middle steps, clamping, floor, masking conditions and retry
    wr(OFF_IRQC, 32'h0000007F);
    wr(OFF_IRQE, 32'h0000001F);
    enable <= 1'b1;
    repeat (5) @(posedge core_clk);
    for (int i = 0; i < 20; i++) begin
      wr(OFF_CTRL, 32'(tbl[i][0]));
      {vset_mv, vout_mv, iout_ma, ramping} <= {16'(tbl[i][1]), 16'(tbl[i][2]), 16'(tbl[i][3]), tbl[i][4] != 0};
      watch(0, 1'b1, 145, 165, tbl[i][5] != 0);
      if (tbl[i][5] != 0) rdc(OFF_STAT, 32'h1F, 32'(tbl[i][5]), "fault cause");
      {vset_mv, vout_mv, iout_ma, ramping} <= {16'h09C4, 16'h09C4, 16'h0000, 1'b0};
      watch(0, 1'b0, tbl[i][5] != 0 ? RCYC - 12 : 0, RCYC + 8, 1'b1);
    end
    rdc(OFF_STAT, 32'h1F, 32'h0, "cause cleared on restart");
    rdc(OFF_IRQS, 32'h1F, 32'h17, "trip history");
    check({31'h0, irq}, 32'h1, "interrupt raised");
    wr(OFF_IRQE, 32'h0);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0, "interrupt masked");
    wr(OFF_IRQE, 32'h1F);
    wr(OFF_IRQC, 32'h1F);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0, "interrupt cleared");
    // Latched overcurrent survives a full retry period, released by disable
    wr(OFF_CTRL, 32'h0000022A);
    iout_ma <= 16'h05E6;
    watch(0, 1'b1, 145, 165, 1'b1);
    rdc(OFF_STAT, 32'h81, 32'h81, "latched cause");
    iout_ma <= 16'h0000;
    watch(0, 1'b0, 0, RCYC + 100, 1'b0);
    enable <= 1'b0;
    watch(0, 1'b0, 0, 10, 1'b1);
    enable <= 1'b1;
    wr(OFF_CTRL, 32'h0000002A);
    // Temperature warning with hysteresis and thermal shutdown restart level
    temp_c <= 8'h78;
    watch(1, 1'b1, 145, 165, 1'b1);
    temp_c <= 8'h76;
    watch(1, 1'b0, 0, 200, 1'b0);
    temp_c <= 8'h82;
    watch(0, 1'b1, 145, 165, 1'b1);
    rdc(OFF_STAT, 32'h3F, 32'h28, "thermal cause and warning");
    temp_c <= 8'h79;
    watch(0, 1'b0, 0, RCYC + 100, 1'b0);
    temp_c <= 8'h78;
    watch(0, 1'b0, 0, 10, 1'b1);
    temp_c <= 8'h75;
    watch(1, 1'b0, 145, 165, 1'b1);
    test_done();
  end
endmodule

// ---- verilog/pfp_dly.sv ----
// Purpose: Qualifies one condition: output follows after a steady 6 us
// Assumes: Input comes from logic on the same clock
// Notes:   A glitch shorter than the delay is dropped in either direction
`timescale 1ns/1ps
module pfp_dly
  import pfp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Condition
  input  wire logic raw,
  output logic      out_q
);

  logic [7:0] cnt_q;
  wire        diff = raw != out_q;
  wire        done = cnt_q == DLY_LAST;

  ////////////////////////////////////////////////////////////////////////
  // Count cycles of disagreement, take the new level at the end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      out_q <= 1'b0;
    end else begin
      cnt_q <= (diff && !done) ? cnt_q + 8'h01 : 8'h00;
      if (diff && done) begin
        out_q <= raw;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_dly_exact_figure: assert property ($changed(out_q) |-> $past(cnt_q) == DLY_LAST)
    else $error("Qualified level changed before the full delay");
  a_dly_count_up: assert property (diff && !done |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("Delay counter failed to advance");

endmodule

// ---- verilog/pfp_fault_prot.sv ----
// Purpose: Fault protection, warning and power-good supervision of a
//          step-down regulator, with an AHB-Lite register slave
// Assumes: Measurements come from logic on CORE_CLK; ENABLE is a pin
// Notes:   Slave inserts one wait state on every transfer
// How it works
// - Per-fault latching or 130 ms periodic retry
// - Overcurrent 60..150 % in 11 steps, default 150
// - Overvoltage 110..130 % in 10 % steps, default 130
// - Overvoltage trip level never below one volt
// - Undervoltage 75..85 % in 5 % steps, default 75
// - Voltage, temperature, tracking trips act after 6 us
// - Off at 130 C, restart only at 120 C
// - Tracking off by default, latching or retry
// - Tracking trips beyond 250 mV while ramping up
// - Warning at 120 C, clears 3 C lower
// - Warning asserted 6 us after threshold
// - Power good inside 90/95..110 % window
// - Power good changes 6 us after crossing
`timescale 1ns/1ps
module pfp_fault_prot
  import pfp_pkg::*;
#(
  parameter int RETRY_CYC = RETRY_CYC_DEF
)(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Module enable pin and ramp flag
  input  wire logic        ENABLE,
  input  wire logic        RAMPING,
  // Measurements and targets
  input  wire logic [15:0] VOUT_MV,
  input  wire logic [15:0] VSET_MV,
  input  wire logic [15:0] VTRACK_MV,
  input  wire logic [15:0] IOUT_MA,
  input  wire logic [15:0] IRATED_MA,
  input  wire logic [7:0]  TEMP_C,
  // Results
  output logic             TURN_OFF,
  output logic             POWER_GOOD_OUTPUT,
  output logic             OT_WARN,
  output logic             IRQ
);

  // Retry period must exceed the 150-cycle qualifier, else a stale flag retrips
  localparam logic [21:0] RETRY_LAST = 22'(RETRY_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Enable pin synchroniser
  logic en_m_q;
  logic en_s_q;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      en_m_q <= 1'b0;
      en_s_q <= 1'b0;
    end else begin
      en_m_q <= ENABLE;
      en_s_q <= en_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase capture; HSIZE is ignored, words only
  logic       ph_q;
  logic       wr_q;
  logic [7:0] adr_q;
  wire        take = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ph_q      <= 1'b0;
      wr_q      <= 1'b0;
      adr_q     <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      ph_q      <= take;
      HREADYOUT <= !take; // One wait state lets read data leave a flop
      HRESP     <= 1'b0;
      if (take) begin
        wr_q  <= HWRITE;
        adr_q <= HADDR[7:0];
      end
    end
  end

  // Register decode
  wire wr_ctrl  = ph_q && wr_q && adr_q == OFF_CTRL;
  wire wr_irqc  = ph_q && wr_q && adr_q == OFF_IRQC;
  wire wr_irqe  = ph_q && wr_q && adr_q == OFF_IRQE;
  wire rd_go    = ph_q && !wr_q;

  ////////////////////////////////////////////////////////////////////////
  // Software-written registers
  logic [14:0] ctrl_q;
  logic [6:0]  ien_q;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= CTRL_RST;
      ien_q  <= 7'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= HWDATA[14:0];
      end
      if (wr_irqe) begin
        ien_q <= HWDATA[6:0];
      end
    end
  end

  // Field selects, out-of-range codes clamp to the top step
  wire [3:0] oc_raw  = ctrl_q[OC_LSB +: 4];
  wire [3:0] oc_sel  = (oc_raw > OC_MAX) ? OC_MAX : oc_raw;
  wire [1:0] ov_sel  = (ctrl_q[OV_LSB +: 2] > OV_MAX) ? OV_MAX : ctrl_q[OV_LSB +: 2];
  wire [1:0] uv_sel  = (ctrl_q[UV_LSB +: 2] > UV_MAX) ? UV_MAX : ctrl_q[UV_LSB +: 2];
  wire [4:0] lat_sel = ctrl_q[LAT_LSB +: 5];
  wire       trk_en  = ctrl_q[TRK_BIT];

  // Percent levels
  wire [7:0] oc_pct = OC_BASE + OC_STEP * {4'h0, oc_sel};
  wire [7:0] ov_pct = OV_BASE + OV_STEP * {6'h00, ov_sel};
  wire [7:0] uv_pct = UV_BASE + UV_STEP * {6'h00, uv_sel};
  wire [7:0] pg_pct = ctrl_q[PG_BIT] ? PG_LO1 : PG_LO0;

  ////////////////////////////////////////////////////////////////////////
  // Comparisons scaled by 100 so no divider is needed
  wire [23:0] v_x100 = {8'h00, VOUT_MV} * PCT_SCALE;
  wire [23:0] i_x100 = {8'h00, IOUT_MA} * PCT_SCALE;
  wire [23:0] oc_lim = {8'h00, IRATED_MA} * {16'h0000, oc_pct};
  wire [23:0] ov_lim = {8'h00, VSET_MV} * {16'h0000, ov_pct};
  wire [23:0] uv_lim = {8'h00, VSET_MV} * {16'h0000, uv_pct};
  wire [23:0] pg_lo  = {8'h00, VSET_MV} * {16'h0000, pg_pct};
  wire [23:0] pg_hi  = {8'h00, VSET_MV} * {16'h0000, PG_HI};

  // Tracking error magnitude
  wire [15:0] trk_dev = (VOUT_MV >= VTRACK_MV) ? VOUT_MV - VTRACK_MV : VTRACK_MV - VOUT_MV;

  // Protection is armed only while the output is commanded on
  pfp_state_t st_q;
  pfp_state_t st_d;
  wire        armed = en_s_q && st_q == ST_RUN;

  // Raw conditions; sink current never trips overcurrent
  logic [6:0] raw;
  logic       wrn_q;
  assign raw[F_OC]  = armed && !IOUT_MA[15] && i_x100 > oc_lim;
  assign raw[F_OV]  = armed && v_x100 > ov_lim && VOUT_MV > OV_FLOOR;
  assign raw[F_UV]  = armed && !RAMPING && v_x100 < uv_lim;
  assign raw[F_OT]  = armed && TEMP_C >= OT_OFF_C;
  assign raw[F_TRK] = armed && trk_en && RAMPING && trk_dev > TRK_MV;
  assign raw[E_WRN] = wrn_q;
  assign raw[E_PG]  = v_x100 >= pg_lo && v_x100 <= pg_hi;

  // Warning with hysteresis, always active
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wrn_q <= 1'b0;
    end else if (TEMP_C >= WRN_ON_C) begin
      wrn_q <= 1'b1;
    end else if (TEMP_C <= WRN_OFF_C) begin
      wrn_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One 6 us qualifier per condition
  logic [6:0] flt;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_dly
      pfp_dly u_dly (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .raw   (raw[gi]),
        .out_q (flt[gi])
      );
    end
  endgenerate

  wire [4:0] new_trip = (st_q == ST_RUN) ? flt[4:0] : 5'h00;

  ////////////////////////////////////////////////////////////////////////
  // Shutdown state machine
  logic [21:0] cnt_q;
  logic [21:0] cnt_d;
  logic [4:0]  fault_q;
  logic [4:0]  fault_d;
  wire         ot_hot = fault_q[F_OT] && TEMP_C > OT_ON_C;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    fault_d = fault_q;
    unique case (st_q)
      ST_RUN: begin
        if (|new_trip) begin
          fault_d = new_trip;
          cnt_d   = 22'h000000;
          st_d    = (|(new_trip & lat_sel)) ? ST_LATCH : ST_RETRY;
        end
      end
      ST_RETRY: begin
        if (cnt_q != RETRY_LAST) begin
          cnt_d = cnt_q + 22'h000001;
        end else if (!ot_hot) begin
          st_d    = ST_RUN;
          fault_d = 5'h00;
        end
      end
      ST_LATCH: begin
        if (!en_s_q) begin
          st_d    = ST_RUN;
          fault_d = 5'h00;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q    <= ST_RUN;
      cnt_q   <= 22'h000000;
      fault_q <= 5'h00;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      fault_q <= fault_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over a clear in the same cycle
  logic [6:0] irq_q;
  wire  [6:0] ev;
  wire  [6:0] clr = wr_irqc ? HWDATA[6:0] : 7'h00;
  wire  [6:0] irq_d = (irq_q & ~clr) | ev;

  assign ev[4:0]  = new_trip;
  assign ev[E_WRN] = flt[E_WRN] && !OT_WARN;
  assign ev[E_PG]  = flt[E_PG] != POWER_GOOD_OUTPUT;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_q <= 7'h00;
      IRQ   <= 1'b0;
    end else begin
      irq_q <= irq_d;
      IRQ   <= |(irq_d & ien_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      TURN_OFF          <= 1'b0;
      POWER_GOOD_OUTPUT <= 1'b0;
      OT_WARN           <= 1'b0;
    end else begin
      TURN_OFF          <= st_d != ST_RUN;
      POWER_GOOD_OUTPUT <= flt[E_PG];
      OT_WARN           <= flt[E_WRN];
    end
  end

  // Read data mux; unmapped offsets read zero
  wire [31:0] stat_w = {23'h000000, TURN_OFF, st_q == ST_LATCH,
                        POWER_GOOD_OUTPUT, OT_WARN, fault_q};
  wire [31:0] rd_mux =
    (adr_q == OFF_CTRL) ? {17'h00000, ctrl_q} :
    (adr_q == OFF_STAT) ? stat_w :
    (adr_q == OFF_IRQS) ? {25'h0000000, irq_q} :
    (adr_q == OFF_IRQE) ? {25'h0000000, ien_q} : 32'h00000000;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HRDATA <= 32'h00000000;
    end else if (rd_go) begin
      HRDATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_retry_wait_full: assert property (st_q == ST_RETRY && cnt_q != RETRY_LAST
    |=> st_q == ST_RETRY && cnt_q == $past(cnt_q) + 22'h000001)
    else $error("Retry left before its period");
  a_oc_default_level: assert property (ctrl_q[3:0] == OC_MAX && armed && !IOUT_MA[15]
    && i_x100 > {8'h00, IRATED_MA} * 24'h000096 |-> raw[F_OC])
    else $error("Overcurrent missed at the top level");
  a_ov_top_level: assert property (ov_sel == OV_MAX && v_x100 <= {8'h00, VSET_MV} * 24'h000082
    |-> !raw[F_OV])
    else $error("Overvoltage tripped below 130 percent");
  a_ov_volt_floor: assert property (VOUT_MV <= 16'h03E8 |-> !raw[F_OV])
    else $error("Overvoltage tripped below one volt");
  a_uv_low_level: assert property (armed && !RAMPING && uv_sel == 2'h0
    && v_x100 < {8'h00, VSET_MV} * 24'h00004B |-> raw[F_UV])
    else $error("Undervoltage missed at 75 percent");
  a_off_follows_trip: assert property (st_q == ST_RUN && |new_trip |=> TURN_OFF)
    else $error("Turn-off not issued after a trip");
  a_ot_no_restart: assert property (st_q == ST_RETRY && fault_q[F_OT] && TEMP_C > 8'h78
    |=> st_q != ST_RUN)
    else $error("Restart while still hot");
  a_trk_idle_gate: assert property (!trk_en || !RAMPING |-> !raw[F_TRK])
    else $error("Tracking tripped while inactive");
  a_warn_hyst_hold: assert property (wrn_q && TEMP_C > 8'h75 |=> wrn_q)
    else $error("Warning cleared inside hysteresis");
  a_pg_above_window: assert property (v_x100 > pg_hi |-> !raw[E_PG])
    else $error("Window accepted a voltage above 110 percent");
  a_latch_hold_off: assert property (st_q == ST_LATCH && en_s_q |=> st_q == ST_LATCH && TURN_OFF)
    else $error("Latched shutdown released while enabled");
  a_fault_cause_flag: assert property (st_q == ST_RUN && |new_trip
    |=> fault_q == $past(new_trip))
    else $error("Fault cause flags wrong");

  c_retry_restart: cover property (st_q == ST_RETRY ##1 st_q == ST_RUN);
  c_latch_entered: cover property (st_q == ST_RUN ##1 st_q == ST_LATCH);
  c_pg_rises:      cover property ($rose(POWER_GOOD_OUTPUT));
  c_warn_rises:    cover property ($rose(OT_WARN));

endmodule

// ---- verilog/pfp_pkg.sv ----
// Purpose: Shared constants of the regulator fault-protection block
// Assumes: 25 MHz core clock; measurements in mV, mA and whole degrees C
// Notes:   Offsets are byte addresses on the AHB-Lite slave
package pfp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int DLY_US        = 6;
  localparam int DLY_CYC       = DLY_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0] DLY_LAST = 8'(DLY_CYC - 1);
  localparam int RETRY_MS      = 130;
  localparam int RETRY_CYC_DEF = RETRY_MS * (CLK_HZ / 1000);

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_IRQS  = 8'h08;
  localparam logic [7:0] OFF_IRQC  = 8'h0C;
  localparam logic [7:0] OFF_IRQE  = 8'h10;

  // Control fields and reset value (OC 150 %, OV 130 %, UV 75 %, PG 90 %)
  localparam int OC_LSB  = 0;
  localparam int OV_LSB  = 4;
  localparam int UV_LSB  = 6;
  localparam int PG_BIT  = 8;
  localparam int LAT_LSB = 9;
  localparam int TRK_BIT = 14;
  localparam logic [14:0] CTRL_RST = 15'h002A;

  // Fault and event indices
  localparam int F_OC  = 0;
  localparam int F_OV  = 1;
  localparam int F_UV  = 2;
  localparam int F_OT  = 3;
  localparam int F_TRK = 4;
  localparam int E_WRN = 5;
  localparam int E_PG  = 6;

  ////////////////////////////////////////////////////////////////////////
  // Thresholds, percent of rating or setpoint, else in mV or degrees C
  localparam logic [23:0] PCT_SCALE = 24'h000064;
  localparam logic [3:0]  OC_MAX    = 4'hA;
  localparam logic [7:0]  OC_BASE   = 8'h3C;
  localparam logic [7:0]  OC_STEP   = 8'h09;
  localparam logic [1:0]  OV_MAX    = 2'h2;
  localparam logic [7:0]  OV_BASE   = 8'h6E;
  localparam logic [7:0]  OV_STEP   = 8'h0A;
  localparam logic [15:0] OV_FLOOR  = 16'h03E8;
  localparam logic [1:0]  UV_MAX    = 2'h2;
  localparam logic [7:0]  UV_BASE   = 8'h4B;
  localparam logic [7:0]  UV_STEP   = 8'h05;
  localparam logic [7:0]  PG_LO0    = 8'h5A;
  localparam logic [7:0]  PG_LO1    = 8'h5F;
  localparam logic [7:0]  PG_HI     = 8'h6E;
  localparam logic [15:0] TRK_MV    = 16'h00FA;
  localparam logic [7:0]  OT_OFF_C  = 8'h82;
  localparam logic [7:0]  OT_ON_C   = 8'h78;
  localparam logic [7:0]  WRN_ON_C  = 8'h78;
  localparam logic [7:0]  WRN_OFF_C = 8'h75;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_RETRY = 2'b01,
    ST_LATCH = 2'b10
  } pfp_state_t;

endpackage
